// file: pkg/rcos_pkg.sv
package rcos_pkg;
  // Strap bit positions within the three-pin strap group
  localparam int unsigned STRAP_SDRAM = 0;
  localparam int unsigned STRAP_SYS = 1;
  localparam int unsigned STRAP_PCI = 2;
  localparam int unsigned STRAP_W = 3;
  // Reset value of each clock enable: strap pull-up means enabled
  localparam logic EN_RESET = 1'b1;
  // Divider half-period count for the generated clocks
  localparam int unsigned DIV_HALF = 1;
  localparam int unsigned DIV_W = 4;
endpackage : rcos_pkg

// file: src/rcos_clock_out.sv
// Notes on behaviour
// - Straps decide clock enables during reset
// - Disabled clock pin goes high impedance
// - Strap high enables, external pull-down disables
// - Original revision: low strap keeps Hi-Z
// - Corrected revision drives sdram, system clocks
// - Pin config bits disable clocks after boot
// - PCI clock still follows its strap
module rcos_clock_out #(
  parameter bit CORRECTED = 1'b1, // Corrected silicon revision
  parameter int unsigned HALF = rcos_pkg::DIV_HALF // Clock half period in cycles
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Reset sequence and straps
  input wire logic reset_seq_i,
  input wire logic [rcos_pkg::STRAP_W-1:0] strap_i,
  // Pin configuration disables
  input wire logic sdram_clock_disable_i,
  input wire logic system_clock_disable_i,
  // Clock pins
  output logic sdram_clock_out_o,
  output logic sdram_clock_oe_o,
  output logic system_clock_out_o,
  output logic system_clock_oe_o,
  output logic pci_clock_out_o,
  output logic pci_clock_oe_o
);
  // All module state in one record
  typedef struct packed {
    logic [rcos_pkg::DIV_W-1:0] div;
    logic clk;
    logic [rcos_pkg::STRAP_W-1:0] en;
    logic [rcos_pkg::STRAP_W-1:0] oe;
    logic [rcos_pkg::STRAP_W-1:0] out;
  } rcos_state_t;

  rcos_state_t state_q;
  rcos_state_t state_d;
  logic [rcos_pkg::STRAP_W-1:0] sw_dis;

  // Software disables only apply to sdram and system clocks
  assign sw_dis = {1'b0, system_clock_disable_i, sdram_clock_disable_i};

  // Next state
  always_comb begin
    state_d = state_q;
    // Free-running divider for the clock pins
    if (state_q.div == rcos_pkg::DIV_W'(HALF - 1)) begin
      state_d.div = '0;
      state_d.clk = ~state_q.clk;
    end else begin
      state_d.div = state_q.div + 1'b1;
    end
    if (reset_seq_i) begin
      // Strap sample; pull-up high enables, pull-down low disables
      state_d.en = strap_i;
      // Corrected part keeps sdram and system clocks running in reset
      if (CORRECTED) begin
        state_d.en[rcos_pkg::STRAP_SDRAM] = 1'b1;
        state_d.en[rcos_pkg::STRAP_SYS] = 1'b1;
      end
      // Pci clock always follows its strap
      state_d.en[rcos_pkg::STRAP_PCI] = strap_i[rcos_pkg::STRAP_PCI];
    end
    // Pins: drive only when enabled and not disabled by software
    for (int i = 0; i < rcos_pkg::STRAP_W; i++) begin
      // Original part: a low strap in reset holds Hi-Z until it rises
      state_d.oe[i] = state_d.en[i] & ~(sw_dis[i] & ~reset_seq_i);
      state_d.out[i] = state_d.oe[i] & state_d.clk;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= '{div: '0, clk: 1'b0, en: {rcos_pkg::STRAP_W{rcos_pkg::EN_RESET}}, oe: '0, out: '0};
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  assign sdram_clock_out_o = state_q.out[rcos_pkg::STRAP_SDRAM];
  assign sdram_clock_oe_o = state_q.oe[rcos_pkg::STRAP_SDRAM];
  assign system_clock_out_o = state_q.out[rcos_pkg::STRAP_SYS];
  assign system_clock_oe_o = state_q.oe[rcos_pkg::STRAP_SYS];
  assign pci_clock_out_o = state_q.out[rcos_pkg::STRAP_PCI];
  assign pci_clock_oe_o = state_q.oe[rcos_pkg::STRAP_PCI];

  // Corrected part drives sdram clock throughout reset sequence
  a_sdram_in_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (CORRECTED && ce_i && reset_seq_i) |=> sdram_clock_oe_o)
    else $error("sdram clock not driven in reset");
  a_system_in_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (CORRECTED && ce_i && reset_seq_i) |=> system_clock_oe_o)
    else $error("system clock not driven in reset");
  a_pci_strap_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && reset_seq_i && !strap_i[rcos_pkg::STRAP_PCI]) |=> !pci_clock_oe_o)
    else $error("pci clock driven with low strap");
  a_sw_disable: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && !reset_seq_i && sdram_clock_disable_i) |=> !sdram_clock_oe_o && !sdram_clock_out_o)
    else $error("sdram clock driven while disabled");
  a_hiz_no_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !pci_clock_oe_o |-> !pci_clock_out_o)
    else $error("pci clock toggles while released");
  // Pci strap high in reset must turn its pin on
  a_pci_strap_high: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && reset_seq_i && strap_i[rcos_pkg::STRAP_PCI]) |=> pci_clock_oe_o)
    else $error("pci clock released with high strap");
  // Original part: low strap in reset keeps sdram pin released
  a_orig_strap_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!CORRECTED && ce_i && reset_seq_i && !strap_i[rcos_pkg::STRAP_SDRAM]) |=> !sdram_clock_oe_o)
    else $error("sdram clock driven with low strap");
  // Enable low freezes every state bit, pins included
  a_ce_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !ce_i |=> $stable(state_q))
    else $error("state moved while clock enable low");
endmodule : rcos_clock_out

// file: dv/rcos_board.sv
module rcos_board (
  // Board pull-down fitted on each strap
  input wire logic [2:0] pd_i,
  // Strap levels seen by the device
  output logic [2:0] strap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // On-chip pull-up wins unless a pull-down is fitted
  assign strap_o = ~pd_i;
endmodule : rcos_board

// file: dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus held by the bench
  logic clk_i = 0, resetn_i = 0, seq = 1, dis_s = 0, dis_y = 0, ce = 1;
  // Original revision pins
  logic [2:0] oe_b, co_b;
  logic [2:0] pd = 3'h0;
  // Observed pins: bit0 sdram, bit1 system, bit2 pci
  logic [2:0] st, oe, co;
  int error_cnt = 0, checks = 0;
  initial forever #4 clk_i = ~clk_i;
  rcos_board i_rcos_board (.pd_i(pd), .strap_o(st));
  rcos_clock_out #(.CORRECTED(1'b0)) i_rcos_clock_out_orig (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .reset_seq_i(seq), .strap_i(st), .sdram_clock_disable_i(dis_s),
    .system_clock_disable_i(dis_y), .sdram_clock_out_o(co_b[0]), .sdram_clock_oe_o(oe_b[0]),
    .system_clock_out_o(co_b[1]), .system_clock_oe_o(oe_b[1]), .pci_clock_out_o(co_b[2]),
    .pci_clock_oe_o(oe_b[2]));
  rcos_clock_out i_rcos_clock_out (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .reset_seq_i(seq), .strap_i(st), .sdram_clock_disable_i(dis_s),
    .system_clock_disable_i(dis_y), .sdram_clock_out_o(co[0]), .sdram_clock_oe_o(oe[0]),
    .system_clock_out_o(co[1]), .system_clock_oe_o(oe[1]), .pci_clock_out_o(co[2]),
    .pci_clock_oe_o(oe[2]));
  // Two edges of slack so enable and pin stages settle
  // Driven pins must also toggle each cycle while enable is high
  task chk(input logic [2:0] e);
    logic [2:0] c1;
    repeat (2) @(negedge clk_i);
    c1 = co;
    @(negedge clk_i);
    checks++;
    if (oe !== e || (co & ~oe) !== 3'h0 || (ce === 1'b1 && (co ^ c1) !== oe)) begin
      error_cnt++;
      $display("Error %0t oe %b out %b", $time, oe, co);
    end
  endtask : chk
  // Pin and tristate check on the original revision instance, without the toggle check
  task chk_b(input logic [2:0] e);
    repeat (2) @(negedge clk_i);
    checks++;
    if (oe_b !== e || (co_b & ~oe_b) !== 3'h0) begin
      error_cnt++;
      $display("Error %0t orig oe %b out %b", $time, oe_b, co_b);
    end
  endtask : chk_b
  // Original part releases all pins on low straps until they rise
  task orig_rev;
    seq = 1;
    pd = 3'h7;
    chk(3'h3);
    chk_b(3'h0);
    pd = 3'h0;
    chk_b(3'h7);
  endtask : orig_rev
  // Enable low freezes pins; mid-run reset releases them
  task freeze_reset;
    ce = 0;
    pd = 3'h7;
    chk(3'h7);
    ce = 1;
    resetn_i = 0;
    @(negedge clk_i);
    checks++;
    if (oe !== 3'h0 || co !== 3'h0) begin
      error_cnt++;
      $display("Error %0t reset oe %b out %b", $time, oe, co);
    end
    resetn_i = 1;
    chk(3'h3);
  endtask : freeze_reset
  // All straps pulled up: every clock driven
  task straps_high;
    pd = 3'h0;
    chk(3'h7);
  endtask : straps_high
  // All pulled down, then sdram and system only: only pci follows its strap
  task straps_low;
    pd = 3'h7;
    chk(3'h3);
    pd = 3'h3;
    chk(3'h7);
  endtask : straps_low
  // Disables ignored in reset, honoured after boot
  task late_dis;
    dis_s = 1;
    dis_y = 1;
    chk(3'h7);
    seq = 0;
    dis_y = 0;
    chk(3'h6);
    dis_y = 1;
    chk(3'h4);
  endtask : late_dis
  task summarize;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Reset held six cycles, clocked devices reset with it
  initial begin
    repeat (6) @(negedge clk_i);
    resetn_i = 1;
    straps_high();
    straps_low();
    late_dis();
    orig_rev();
    freeze_reset();
    summarize();
  end
endmodule : tb
